// ==== verilog/sfc_regs.vh ====
// Purpose: shared constants of the serial flash command decoder
// Assumes: included by bare name from the decoder files
// Notes: definitions only
`ifndef SFC_REGS_VH
`define SFC_REGS_VH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_RSR1 8'h05
`define OP_RSR2 8'h35
`define OP_RSR3 8'h15
`define OP_WSR1 8'h01
`define OP_WSR2 8'h31
`define OP_WSR3 8'h11
`define OP_REXT 8'hc8
`define OP_WEXT 8'hc5
`define OP_RD 8'h03
`define OP_RD4 8'h13
`define OP_FRD 8'h0b
`define OP_FRD4 8'h0c
`define OP_SFDP 8'h5a
`define OP_RSEC 8'h48
`define OP_PSEC 8'h42
`define OP_ESEC 8'h44
`define OP_DOR 8'h3b
`define OP_DOR4 8'h3c
`define OP_QOR 8'h6b
`define OP_QOR4 8'h6c
`define OP_DIO 8'hbb
`define OP_DIO4 8'hbc
`define OP_QIO 8'heb
`define OP_QIO4 8'hec
`define OP_DID 8'h92
`define OP_QID 8'h94
`define OP_PP 8'h02
`define OP_PP4 8'h12
`define OP_QPP 8'h32
`define OP_QPP4 8'h34
`define OP_WRAP 8'h77
`define OP_RLCK 8'h3d
`define OP_LCK1 8'h36
`define OP_ULK1 8'h39
`define OP_SE 8'h20
`define OP_SE4 8'h21
`define OP_BE32 8'h52
`define OP_BE64 8'hd8
`define OP_BE644 8'hdc
`define OP_WEN 8'h06
`define OP_WDI 8'h04
`define OP_VWEN 8'h50
`define OP_GLCK 8'h7e
`define OP_GULK 8'h98
`define OP_PDN 8'hb9
`define OP_CE1 8'hc7
`define OP_CE2 8'h60
`define OP_RSTE 8'h66
`define OP_RST 8'h99
`define OP_SUSP 8'h75
`define OP_RESM 8'h7a
`define OP_EN4 8'hb7
`define OP_EX4 8'he9
// ----------------------------------------
// Lanes, sources, counts
// ----------------------------------------
`define LC1 2'h0
`define LC2 2'h1
`define LC4 2'h2
`define OE1 4'h2
`define OE2 4'h3
`define OE4 4'hf
`define SRC_MEM 3'h0
`define SRC_SR1 3'h1
`define SRC_SR2 3'h2
`define SRC_SR3 3'h3
`define SRC_EXT 3'h4
`define SRC_ID 3'h5
`define SRC_LCK 3'h6
`define AB3 3'h3
`define AB4 3'h4
`define WRAP_AB 3'h5
`define OP_CLKS 6'h08
`define BYTE_CLKS 6'h08
`define DUM_CLKS 4'h8
`define QDUM_CLKS 4'h4
`define SEC_HI 8'h00
`define SEC1 8'h10
`define SEC2 8'h20
`define SEC3 8'h30
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADDR4_RST 1'b1
`define EXT_RST 8'h00
`define WRAP_RST 8'h00
`endif

// ==== verilog/sfc_fifo.v ====
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: full and empty come from an explicit occupancy count
`timescale 1ns/1ps
module sfc_fifo #(
	parameter W = 16,
	parameter D = 16,
	parameter AW = 4
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	input wire ce,
	// Fill side
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	// Drain side
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wp_reg;
	reg [AW-1:0] rp_reg;
	reg [AW:0] cnt_reg;
	wire push;
	wire pop;

	// Handshakes; full stalls the filler
	assign in_ready = (cnt_reg != D[AW:0]);
	assign out_valid = (cnt_reg != {(AW+1){1'b0}});
	assign out_data = mem[rp_reg];
	assign push = in_valid & in_ready & ce;
	assign pop = out_valid & out_ready & ce;

	// Storage has no reset; only pointers matter
	always @(posedge clk) begin
		if (push) begin
			mem[wp_reg] <= in_data;
		end
	end

	// Pointers and occupancy
	always @(posedge clk) begin
		if (rst) begin
			wp_reg <= {AW{1'b0}};
			rp_reg <= {AW{1'b0}};
			cnt_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wp_reg <= (wp_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_reg + 1'b1;
			end
			if (pop) begin
				rp_reg <= (rp_reg == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_reg + 1'b1;
			end
			if (push & ~pop) begin
				cnt_reg <= cnt_reg + 1'b1;
			end else if (pop & ~push) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
endmodule

// ==== verilog/sfc_core.v ====
// Purpose: opcode decoder and lane formatter of a serial NOR flash
// Assumes: host drives chip select, serial clock and lanes; the
//   serial clock is oversampled by clk (at least 8 clk per period)
// Notes: inputs are sampled on serial clock rise, outputs change on fall
// Notes on behaviour
// - All bytes move most significant bit first
// - Status and ID reads repeat until deselect
// - Program takes one byte or more, with no upper limit, offset wraps in page
// - Security areas at 10h/20h/30h, upper byte zero
// - Dual address: lane one odd, lane zero even
// - Dual data out: lane one odd bits
// - Quad address: one nibble per clock
// - Quad data: high nibble then low nibble
// - Quad I/O read: four idle clocks, then nibbles
// - Wrap bits on lanes 0-2, second-to-last clock
// - C8h returns extension byte, C5h loads it
// - 75h suspends, 7Ah resumes, no further bytes
// - B7h enters, E9h leaves four-byte addressing
// - 3Bh: single address and dummy, dual data
// - 94h: quad address, mode, dummy, maker/part codes
// - 92h: dual address, mode, maker/part codes
`timescale 1ns/1ps
`include "sfc_regs.vh"
module sfc_core #(
	parameter MAKER_CODE = 8'h5a, // Arbitrary value
	parameter PART_CODE = 8'ha5, // Arbitrary value
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW = 4
) (
	// Clock, reset, enable
	input wire clk,
	input wire rst,
	input wire ce,
	// Serial pins
	input wire cs_n,
	input wire sclk,
	input wire [3:0] io_in,
	output wire [3:0] io_out,
	output wire [3:0] io_oe,
	// Array read port
	output wire [31:0] cmd_addr,
	input wire [7:0] rd_byte,
	// Byte sources for register reads
	input wire [7:0] status1,
	input wire [7:0] status2,
	input wire [7:0] status3,
	input wire [7:0] lock_byte,
	// Program data stream
	output wire pg_valid,
	input wire pg_ready,
	output wire [15:0] pg_data,
	output wire pg_overrun,
	// Command reports
	output wire op_pulse,
	output wire [7:0] op_code,
	output wire [7:0] op_data,
	output wire susp_pulse,
	output wire resume_pulse,
	output wire [1:0] sec_area,
	// Mode state
	output wire four_byte_mode,
	output wire [7:0] upper_address_extension_byte,
	output wire [7:0] wrap_setting_byte,
	output wire [7:0] continuous_read_mode_byte
);
	localparam S_OP = 7'h01;
	localparam S_ADDR = 7'h02;
	localparam S_MODE = 7'h04;
	localparam S_DUM = 7'h08;
	localparam S_DIN = 7'h10;
	localparam S_DOUT = 7'h20;
	localparam S_END = 7'h40;

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg cs_n_s1, cs_n_s2, cs_n_s3;
	reg sclk_s1, sclk_s2, sclk_s3;
	reg [3:0] io_s1, io_s2;
	reg [6:0] state_reg;
	reg [5:0] ccnt_reg;
	reg [2:0] bcnt_reg;
	reg [31:0] in_sh_reg;
	reg [7:0] cur_reg;
	reg [7:0] op_reg;
	reg [2:0] ab_reg;
	reg [1:0] alc_reg, olc_reg, ilc_reg;
	reg md_reg, prog_reg, done_reg, ign_reg, id_sel_reg;
	reg [3:0] dm_reg;
	reg [6:0] post_reg;
	reg [2:0] src_reg;
	reg [31:0] addr_reg;
	reg [7:0] off_reg;
	reg [3:0] io_out_reg, io_oe_reg;
	reg addr4_reg;
	reg [7:0] ext_reg, wrap_reg, crm_reg, opd_reg;
	reg [1:0] sec_reg;
	reg op_p_reg, susp_reg, resm_reg, ovr_reg;

	// Decode results
	reg d_ok, d_md, d_prog;
	reg [2:0] d_ab, d_src;
	reg [1:0] d_alc, d_olc, d_ilc;
	reg [3:0] d_dm;
	reg [6:0] d_post;
	reg [1:0] lc;
	reg [5:0] plen;
	reg [7:0] src_byte;
	reg [6:0] nxt;

	wire rise = sclk_s2 & ~sclk_s3 & ~cs_n_s2;
	wire fall = ~sclk_s2 & sclk_s3 & ~cs_n_s2;
	wire cs_end = cs_n_s2 & ~cs_n_s3;
	wire [2:0] ab_m = addr4_reg ? `AB4 : `AB3;
	wire [7:0] opb = {in_sh_reg[6:0], io_s2[0]};
	wire last = (ccnt_reg == plen - 6'h01);
	wire [31:0] in_nx;
	wire push;
	wire fifo_rdy;
	wire [7:0] ob;

	// Shift in one clock worth of lanes, oldest bit at the top
	function [31:0] shin;
		input [31:0] s;
		input [3:0] io;
		input [1:0] c;
		begin
			case (c)
				`LC2: shin = {s[29:0], io[1:0]};
				`LC4: shin = {s[27:0], io};
				default: shin = {s[30:0], io[0]};
			endcase
		end
	endfunction

	// Phase that follows the opcode, address or mode phase
	function [6:0] after;
		input m;
		input [3:0] d;
		input [6:0] p;
		begin
			after = m ? S_MODE : ((d != 4'h0) ? S_DUM : p);
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Two stages each; third stage only feeds edge detection
	always @(posedge clk) begin
		if (rst) begin
			cs_n_s1 <= 1'b1;
			cs_n_s2 <= 1'b1;
			cs_n_s3 <= 1'b1;
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			io_s1 <= 4'h0;
			io_s2 <= 4'h0;
		end else if (ce) begin
			cs_n_s1 <= cs_n;
			cs_n_s2 <= cs_n_s1;
			cs_n_s3 <= cs_n_s2;
			sclk_s1 <= sclk;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			io_s1 <= io_in;
			io_s2 <= io_s1;
		end
	end

	// ----------------------------------------
	// Opcode decode
	// ----------------------------------------
	// Unlisted opcodes leave d_ok low and the frame is ignored
	always @* begin
		d_ok = 1'b1;
		d_ab = 3'h0;
		d_alc = `LC1;
		d_md = 1'b0;
		d_dm = 4'h0;
		d_post = S_END;
		d_olc = `LC1;
		d_ilc = `LC1;
		d_src = `SRC_MEM;
		d_prog = 1'b0;
		case (opb)
			`OP_RSR1, `OP_RSR2, `OP_RSR3: begin
				d_post = S_DOUT;
				d_src = (opb == `OP_RSR1) ? `SRC_SR1 : ((opb == `OP_RSR2) ? `SRC_SR2 : `SRC_SR3);
			end
			`OP_REXT: begin
				d_post = S_DOUT;
				d_src = `SRC_EXT;
			end
			`OP_WEXT, `OP_WSR1, `OP_WSR2, `OP_WSR3: d_post = S_DIN;
			`OP_RD, `OP_RD4: begin
				d_ab = (opb == `OP_RD4) ? `AB4 : ab_m;
				d_post = S_DOUT;
			end
			`OP_FRD, `OP_FRD4, `OP_RSEC, `OP_SFDP: begin
				d_ab = (opb == `OP_FRD4) ? `AB4 : ((opb == `OP_SFDP) ? `AB3 : ab_m);
				d_dm = `DUM_CLKS;
				d_post = S_DOUT;
			end
			`OP_DOR, `OP_DOR4, `OP_QOR, `OP_QOR4: begin
				d_ab = (opb == `OP_DOR || opb == `OP_QOR) ? ab_m : `AB4;
				d_dm = `DUM_CLKS;
				d_olc = (opb == `OP_DOR || opb == `OP_DOR4) ? `LC2 : `LC4;
				d_post = S_DOUT;
			end
			`OP_DIO, `OP_DIO4, `OP_DID: begin
				d_ab = (opb == `OP_DIO4) ? `AB4 : ab_m;
				d_alc = `LC2;
				d_md = 1'b1;
				d_olc = `LC2;
				d_src = (opb == `OP_DID) ? `SRC_ID : `SRC_MEM;
				d_post = S_DOUT;
			end
			`OP_QIO, `OP_QIO4, `OP_QID: begin
				d_ab = (opb == `OP_QIO4) ? `AB4 : ab_m;
				d_alc = `LC4;
				d_md = 1'b1;
				d_dm = `QDUM_CLKS;
				d_olc = `LC4;
				d_src = (opb == `OP_QID) ? `SRC_ID : `SRC_MEM;
				d_post = S_DOUT;
			end
			`OP_PP, `OP_PP4, `OP_PSEC, `OP_QPP, `OP_QPP4: begin
				d_ab = (opb == `OP_PP4 || opb == `OP_QPP4) ? `AB4 : ab_m;
				d_ilc = (opb == `OP_QPP || opb == `OP_QPP4) ? `LC4 : `LC1;
				d_prog = 1'b1;
				d_post = S_DIN;
			end
			`OP_WRAP: begin
				d_ab = `WRAP_AB;
				d_alc = `LC4;
			end
			`OP_RLCK: begin
				d_ab = ab_m;
				d_src = `SRC_LCK;
				d_post = S_DOUT;
			end
			`OP_SE, `OP_BE32, `OP_BE64, `OP_ESEC, `OP_LCK1, `OP_ULK1: d_ab = ab_m;
			`OP_SE4, `OP_BE644: d_ab = `AB4;
			`OP_WEN, `OP_WDI, `OP_VWEN, `OP_GLCK, `OP_GULK, `OP_PDN: d_ok = 1'b1;
			`OP_CE1, `OP_CE2, `OP_RSTE, `OP_RST, `OP_SUSP, `OP_RESM: d_ok = 1'b1;
			`OP_EN4, `OP_EX4: d_ok = 1'b1;
			default: d_ok = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Phase length, lanes and next phase
	// ----------------------------------------
	always @* begin
		lc = `LC1;
		plen = `OP_CLKS;
		nxt = S_END;
		case (state_reg)
			S_OP: nxt = !d_ok ? S_END : ((d_ab != 3'h0) ? S_ADDR : after(d_md, d_dm, d_post));
			S_ADDR: begin
				lc = alc_reg;
				plen = {ab_reg, 3'h0} >> alc_reg;
				nxt = after(md_reg, dm_reg, post_reg);
			end
			S_MODE: begin
				lc = alc_reg;
				plen = `BYTE_CLKS >> alc_reg;
				nxt = after(1'b0, dm_reg, post_reg);
			end
			S_DUM: begin
				plen = {2'h0, dm_reg};
				nxt = post_reg;
			end
			S_DIN: begin
				lc = ilc_reg;
				plen = `BYTE_CLKS >> ilc_reg;
				nxt = S_DIN;
			end
			default: nxt = state_reg;
		endcase
	end

	// Byte offered to the output lanes
	always @* begin
		case (src_reg)
			`SRC_SR1: src_byte = status1;
			`SRC_SR2: src_byte = status2;
			`SRC_SR3: src_byte = status3;
			`SRC_EXT: src_byte = ext_reg;
			`SRC_ID: src_byte = id_sel_reg ? PART_CODE[7:0] : MAKER_CODE[7:0];
			`SRC_LCK: src_byte = lock_byte;
			default: src_byte = rd_byte;
		endcase
	end

	assign in_nx = shin(in_sh_reg, io_s2, lc);
	assign ob = (bcnt_reg == 3'h0) ? src_byte : cur_reg;
	assign push = rise & (state_reg == S_DIN) & last & prog_reg;

	// ----------------------------------------
	// Frame engine
	// ----------------------------------------
	// Rise samples lanes; fall drives lanes; deselect closes the frame
	always @(posedge clk) begin
		if (rst) begin
			state_reg <= S_OP;
			ccnt_reg <= 6'h00;
			bcnt_reg <= 3'h0;
			in_sh_reg <= 32'h0;
			cur_reg <= 8'h00;
			op_reg <= 8'h00;
			ab_reg <= 3'h0;
			alc_reg <= `LC1;
			olc_reg <= `LC1;
			ilc_reg <= `LC1;
			md_reg <= 1'b0;
			dm_reg <= 4'h0;
			post_reg <= S_END;
			src_reg <= `SRC_MEM;
			prog_reg <= 1'b0;
			done_reg <= 1'b0;
			ign_reg <= 1'b0;
			id_sel_reg <= 1'b0;
			addr_reg <= 32'h0;
			off_reg <= 8'h00;
			io_out_reg <= 4'h0;
			io_oe_reg <= 4'h0;
			addr4_reg <= `ADDR4_RST;
			ext_reg <= `EXT_RST;
			wrap_reg <= `WRAP_RST;
			crm_reg <= 8'h00;
			opd_reg <= 8'h00;
			sec_reg <= 2'h0;
			op_p_reg <= 1'b0;
			susp_reg <= 1'b0;
			resm_reg <= 1'b0;
			ovr_reg <= 1'b0;
		end else if (ce) begin
			op_p_reg <= 1'b0;
			susp_reg <= 1'b0;
			resm_reg <= 1'b0;
			if (cs_n_s2) begin
				// Idle between frames; lanes released
				state_reg <= S_OP;
				ccnt_reg <= 6'h00;
				bcnt_reg <= 3'h0;
				io_oe_reg <= 4'h0;
				id_sel_reg <= 1'b0;
				done_reg <= 1'b0;
				ign_reg <= 1'b0;
				op_p_reg <= cs_end & done_reg & ~ign_reg;
			end else if (rise && state_reg != S_END && state_reg != S_DOUT) begin
				in_sh_reg <= in_nx;
				ccnt_reg <= last ? 6'h00 : ccnt_reg + 6'h01;
				if (last) begin
					state_reg <= nxt;
					if (nxt == S_END || nxt == S_DOUT) begin
						done_reg <= 1'b1;
					end
				end
				if (last && state_reg == S_OP) begin
					op_reg <= opb;
					ign_reg <= ~d_ok;
					ab_reg <= d_ab;
					alc_reg <= d_alc;
					olc_reg <= d_olc;
					ilc_reg <= d_ilc;
					md_reg <= d_md;
					dm_reg <= d_dm;
					post_reg <= d_post;
					src_reg <= d_src;
					prog_reg <= d_prog;
					ovr_reg <= 1'b0;
					susp_reg <= (opb == `OP_SUSP);
					resm_reg <= (opb == `OP_RESM);
					if (opb == `OP_EN4) begin
						addr4_reg <= 1'b1;
					end else if (opb == `OP_EX4) begin
						addr4_reg <= 1'b0;
					end
				end
				if (last && state_reg == S_ADDR) begin
					if (op_reg == `OP_WRAP) begin
						wrap_reg <= {1'b0, in_nx[6:4], 4'h0};
					end else begin
						addr_reg <= (ab_reg == `AB3) ? {ext_reg, in_nx[23:0]} : in_nx;
						off_reg <= in_nx[7:0];
						if (in_nx[23:16] != `SEC_HI) begin
							sec_reg <= 2'h0;
						end else if (in_nx[15:8] == `SEC1) begin
							sec_reg <= 2'h1;
						end else if (in_nx[15:8] == `SEC2) begin
							sec_reg <= 2'h2;
						end else if (in_nx[15:8] == `SEC3) begin
							sec_reg <= 2'h3;
						end else begin
							sec_reg <= 2'h0;
						end
					end
				end
				if (last && state_reg == S_MODE) begin
					crm_reg <= in_nx[7:0];
				end
				if (last && state_reg == S_DIN) begin
					// A program needs one byte before it is reported
					done_reg <= 1'b1;
					opd_reg <= in_nx[7:0];
					if (op_reg == `OP_WEXT) begin
						ext_reg <= in_nx[7:0];
					end
					if (prog_reg) begin
						off_reg <= off_reg + 8'h01;
						if (!fifo_rdy) begin
							ovr_reg <= 1'b1;
						end
					end
				end
			end else if (fall && state_reg == S_DOUT) begin
				// Lane order per width; reloads the source at byte end
				case (olc_reg)
					`LC2: begin
						io_out_reg <= {2'h0, ob[7:6]};
						io_oe_reg <= `OE2;
						cur_reg <= {ob[5:0], 2'h0};
					end
					`LC4: begin
						io_out_reg <= ob[7:4];
						io_oe_reg <= `OE4;
						cur_reg <= {ob[3:0], 4'h0};
					end
					default: begin
						io_out_reg <= {2'h0, ob[7], 1'b0};
						io_oe_reg <= `OE1;
						cur_reg <= {ob[6:0], 1'b0};
					end
				endcase
				if (bcnt_reg == plen_out(olc_reg)) begin
					bcnt_reg <= 3'h0;
					if (src_reg == `SRC_MEM) begin
						addr_reg <= addr_reg + 32'h1;
					end
					id_sel_reg <= ~id_sel_reg;
				end else begin
					bcnt_reg <= bcnt_reg + 3'h1;
				end
			end
		end
	end

	// Index of the last clock of an output byte
	function [2:0] plen_out;
		input [1:0] c;
		begin
			plen_out = 3'h7 >> c;
		end
	endfunction

	// ----------------------------------------
	// Program data buffer
	// ----------------------------------------
	// A full buffer drops the byte and raises the overrun flag
	sfc_fifo #(
		.W(16),
		.D(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.in_valid(push),
		.in_ready(fifo_rdy),
		.in_data({off_reg, in_nx[7:0]}),
		.out_valid(pg_valid),
		.out_ready(pg_ready),
		.out_data(pg_data)
	);

	// Output assignments
	assign io_out = io_out_reg;
	assign io_oe = io_oe_reg;
	assign cmd_addr = addr_reg;
	assign pg_overrun = ovr_reg;
	assign op_pulse = op_p_reg;
	assign op_code = op_reg;
	assign op_data = opd_reg;
	assign susp_pulse = susp_reg;
	assign resume_pulse = resm_reg;
	assign sec_area = sec_reg;
	assign four_byte_mode = addr4_reg;
	assign upper_address_extension_byte = ext_reg;
	assign wrap_setting_byte = wrap_reg;
	assign continuous_read_mode_byte = crm_reg;
endmodule

// ==== verif/sfc_host.sv ====
// Purpose: host controller model driving chip select, serial clock and lanes
// Assumes: mode 0, one serial clock spans 8 system clocks (400 ns)
// Notes: released lanes toggle every serial clock, so stale values never pass
`timescale 1ns/1ps
module sfc_host (
	// Clock
	input wire clk,
	// Serial pins
	output logic cs_n,
	output logic sclk,
	output logic [3:0] io_h,
	input wire [3:0] io_w
);
	// Idle pins; the serial clock stands still outside frames
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		io_h = 4'h0;
	end
	// One serial clock: lanes change in the low half, device lanes are read at the rise
	task automatic tick(input logic [3:0] v, input logic [3:0] en, output logic [3:0] s);
		@(negedge clk);
		sclk = 1'b0;
		io_h = (v & en) | (~io_h & ~en);
		repeat (4) @(negedge clk);
		s = io_w;
		sclk = 1'b1;
		repeat (3) @(negedge clk);
	endtask
	// One byte on 1, 2 or 4 lanes (w = 0, 1, 2); drv low leaves the lanes to the device
	task automatic xfer(input logic [7:0] b, input logic [1:0] w, input logic drv, output logic [7:0] r);
		logic [3:0] s;
		r = 8'h00;
		for (int i = 0; i < ((w == 2'h0) ? 8 : (w == 2'h1) ? 4 : 2); i++) begin
			case (w)
				2'h0: tick({3'h0, b[7-i]}, {3'h0, drv}, s);
				2'h1: tick({2'h0, b[7-2*i], b[6-2*i]}, {2'h0, drv, drv}, s);
				default: tick(b[7-4*i -: 4], {4{drv}}, s);
			endcase
			r = (w == 2'h0) ? {r[6:0], s[1]} : (w == 2'h1) ? {r[5:0], s[1:0]} : {r[3:0], s};
		end
	endtask
	// Frame edges, with settling time for the device's synchroniser
	task automatic start;
		@(negedge clk);
		cs_n = 1'b0;
		repeat (4) @(negedge clk);
	endtask
	task automatic stop;
		@(negedge clk);
		sclk = 1'b0;
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		repeat (8) @(negedge clk);
	endtask
endmodule

// ==== verif/sfc_core_monitor.sv ====
// Purpose: protocol checker for the flash command decoder
// Assumes: bound to sfc_core, one clock domain
// Notes: mode flags are tied to the opcode reports that cause them
`timescale 1ns/1ps
`include "sfc_regs.vh"
module sfc_core_monitor (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Pins and stream
	input wire cs_n,
	input wire [3:0] io_oe,
	input wire pg_valid,
	input wire pg_ready,
	input wire [15:0] pg_data,
	// Reports and mode
	input wire op_pulse,
	input wire [7:0] op_code,
	input wire [7:0] op_data,
	input wire [31:0] cmd_addr,
	input wire susp_pulse,
	input wire resume_pulse,
	input wire [1:0] sec_area,
	input wire four_byte_mode,
	input wire [7:0] upper_address_extension_byte,
	input wire [7:0] wrap_setting_byte
);
	// ----
	// Sequences
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_done(logic [7:0] c);
		op_pulse && op_code == c;
	endsequence
	sequence s_stall;
		pg_valid && !pg_ready;
	endsequence
	// ----
	// Properties
	// ----
	// Reset check lifts the disable, else its antecedent could never hold
	a_reset_state: assert property (disable iff (1'b0) rst |=> io_oe == 4'h0 && four_byte_mode && !pg_valid)
		else $error("state after reset wrong");
	a_idle_release: assert property (cs_n [*6] |-> io_oe == 4'h0)
		else $error("lanes driven while deselected");
	a_susp_report: assert property (susp_pulse |-> !resume_pulse ##1 !susp_pulse ##[0:60] s_done(`OP_SUSP))
		else $error("suspend pulse without its opcode");
	a_enter_four: assert property (s_done(`OP_EN4) |-> ##[0:2] four_byte_mode)
		else $error("four-byte mode not entered");
	a_exit_four: assert property (s_done(`OP_EX4) |-> ##[0:2] !four_byte_mode)
		else $error("four-byte mode not left");
	a_ext_load: assert property (s_done(`OP_WEXT) |-> ##[0:2] upper_address_extension_byte == op_data)
		else $error("extension byte not loaded");
	a_stream_hold: assert property (s_stall |=> pg_valid && $stable(pg_data))
		else $error("program word dropped while stalled");
	a_sec_area: assert property (s_done(`OP_ESEC) ##0 (cmd_addr[23:8] == 16'h0020) |-> ##[0:2] sec_area == 2'h2)
		else $error("security area two not decoded");
	a_wrap_field: assert property (wrap_setting_byte[7] == 1'b0 && wrap_setting_byte[3:0] == 4'h0)
		else $error("wrap byte holds bits outside W6..W4");
	a_lane_width: assert property (io_oe == 4'h0 || io_oe == `OE1 || io_oe == `OE2 || io_oe == `OE4)
		else $error("lane enable pattern illegal");
endmodule

// ==== verif/test_serial_flash_four_byte_command_set.sv ====
// Purpose: self-checking bench of the flash command decoder
// Assumes: host model drives the serial pins, array data follows cmd_addr
// Notes: ce drops once to prove the freeze; stream stalls are made with pg_ready
`timescale 1ns/1ps
`include "sfc_regs.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; $display("Error at %0t: got %h expected %h", $time, a, e); end end
module test_serial_flash_four_byte_command_set;
	// Identity codes: arbitrary values
	localparam logic [7:0] MK = 8'h3e;
	localparam logic [7:0] PT = 8'hc1;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic pg_ready = 1'b0;
	logic [7:0] status1 = 8'ha6, status2 = 8'h5b, status3 = 8'h39, lock_byte = 8'h81, r;
	wire cs_n, sclk, pg_valid, pg_overrun, op_pulse, susp_pulse, resume_pulse, four_byte_mode;
	wire [3:0] io_h, io_out, io_oe;
	wire [1:0] sec_area;
	wire [31:0] cmd_addr;
	wire [15:0] pg_data;
	wire [7:0] op_code, op_data, upper_address_extension_byte, wrap_setting_byte, continuous_read_mode_byte;
	// Lane level: the device where it drives, else the host
	wire [3:0] io_w = (io_oe & io_out) | (~io_oe & io_h);
	wire [7:0] rd_byte = cmd_addr[7:0] ^ 8'h3c;
	int failures = 0, num_checks = 0, n_op = 0, n_susp = 0, n_res = 0;
	always #25 clk = ~clk;
	// Pulse counters; a doubled pulse would show as a count off by one
	always @(posedge clk) begin
		if (op_pulse === 1'b1) n_op <= n_op + 1;
		if (susp_pulse === 1'b1) n_susp <= n_susp + 1;
		if (resume_pulse === 1'b1) n_res <= n_res + 1;
	end
	sfc_core #(.MAKER_CODE(MK), .PART_CODE(PT), .FIFO_DEPTH(16), .FIFO_AW(4)) i_dut (.clk, .rst, .ce, .cs_n, .sclk,
		.io_in(io_w), .io_out, .io_oe, .cmd_addr, .rd_byte, .status1, .status2, .status3, .lock_byte, .pg_valid,
		.pg_ready, .pg_data, .pg_overrun, .op_pulse, .op_code, .op_data, .susp_pulse, .resume_pulse, .sec_area,
		.four_byte_mode, .upper_address_extension_byte, .wrap_setting_byte, .continuous_read_mode_byte);
	sfc_host i_host (.clk, .cs_n, .sclk, .io_h, .io_w);
	// ----
	// Helpers
	// ----
	task automatic sb(input logic [7:0] b);
		i_host.xfer(b, 2'h0, 1'b1, r);
	endtask
	task automatic op1(input logic [7:0] b);
		i_host.start();
		sb(b);
		i_host.stop();
	endtask
	task automatic addr4(input logic [31:0] a, input logic [1:0] w);
		for (int i = 0; i < 4; i++) i_host.xfer(a[31-8*i -: 8], w, 1'b1, r);
	endtask
	task automatic rd_reg(input logic [7:0] op, input logic [7:0] e);
		i_host.start();
		sb(op);
		i_host.xfer(8'h00, 2'h0, 1'b0, r);
		`CHK(r, e)
		i_host.xfer(8'h00, 2'h0, 1'b0, r);
		`CHK(r, e)
		`CHK(io_oe, `OE1)
		i_host.stop();
	endtask
	task automatic summarize;
		$display("Comparisons: %0d, mismatches: %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_ext;
		op1(`OP_WEN);
		i_host.start();
		sb(`OP_WEXT);
		sb(8'hc3);
		i_host.stop();
		`CHK(upper_address_extension_byte, 8'hc3)
		`CHK(op_code, `OP_WEXT)
		`CHK(op_data, 8'hc3)
		rd_reg(`OP_REXT, 8'hc3);
	endtask
	task automatic t_mode;
		int o, s, q;
		o = n_op;
		s = n_susp;
		q = n_res;
		op1(`OP_EX4);
		`CHK(four_byte_mode, 1'b0)
		// Three address bytes now; the extension byte supplies the top byte
		i_host.start();
		sb(`OP_RD);
		for (int i = 0; i < 3; i++) sb(8'h21 + i[7:0]);
		i_host.xfer(8'h00, 2'h0, 1'b0, r);
		i_host.stop();
		`CHK(r, 8'h23 ^ 8'h3c)
		`CHK(cmd_addr, 32'hc3212224)
		op1(`OP_EN4);
		`CHK(four_byte_mode, 1'b1)
		op1(`OP_SUSP);
		op1(`OP_RESM);
		`CHK(n_susp, s + 1)
		`CHK(n_res, q + 1)
		`CHK(n_op, o + 5)
	endtask
	task automatic t_dor;
		i_host.start();
		sb(`OP_DOR);
		addr4(32'h00001240, 2'h0);
		sb(8'h00);
		i_host.xfer(8'h00, 2'h1, 1'b0, r);
		`CHK(r, 8'h7c)
		i_host.xfer(8'h00, 2'h1, 1'b0, r);
		`CHK(r, 8'h7d)
		i_host.stop();
	endtask
	task automatic t_qio;
		i_host.start();
		sb(`OP_QIO);
		addr4(32'h00000080, 2'h2);
		i_host.xfer(8'hf0, 2'h2, 1'b1, r);
		i_host.xfer(8'h00, 2'h2, 1'b0, r);
		`CHK(io_oe, 4'h0)
		i_host.xfer(8'h00, 2'h2, 1'b0, r);
		i_host.xfer(8'h00, 2'h2, 1'b0, r);
		`CHK(r, 8'hbc)
		i_host.xfer(8'h00, 2'h2, 1'b0, r);
		`CHK(r, 8'hbd)
		i_host.stop();
		`CHK(continuous_read_mode_byte, 8'hf0)
	endtask
	task automatic t_did;
		i_host.start();
		sb(`OP_DID);
		addr4(32'h00001200, 2'h1);
		i_host.xfer(8'hf0, 2'h1, 1'b1, r);
		i_host.xfer(8'h00, 2'h1, 1'b0, r);
		`CHK(r, MK)
		i_host.xfer(8'h00, 2'h1, 1'b0, r);
		`CHK(r, PT)
		i_host.stop();
	endtask
	// Seventeen bytes into a stalled 16-word buffer, then drained; offsets wrap past ffh
	task automatic t_prog;
		int k;
		op1(`OP_WEN);
		i_host.start();
		sb(`OP_PP);
		addr4(32'h000004fe, 2'h0);
		for (int i = 0; i < 17; i++) sb(i[7:0]);
		i_host.stop();
		`CHK(pg_overrun, 1'b1)
		// Enable low must freeze the drain side too; word 0 is checked below
		ce = 1'b0;
		pg_ready = 1'b1;
		repeat (4) @(negedge clk);
		`CHK(pg_valid, 1'b1)
		ce = 1'b1;
		for (int i = 0; i < 16; i++) begin
			k = 0;
			while (pg_valid !== 1'b1 && k < 50) begin
				@(negedge clk);
				k++;
			end
			if (k == 50) begin
				$display("Error at %0t: program word timed out", $time);
				failures++;
				summarize();
			end
			`CHK(pg_data, {i[7:0] + 8'hfe, i[7:0]})
			@(negedge clk);
		end
		repeat (2) @(negedge clk);
		`CHK(pg_valid, 1'b0)
		pg_ready = 1'b0;
	endtask
	task automatic t_sec;
		for (int a = 1; a < 4; a++) begin
			op1(`OP_WEN);
			i_host.start();
			sb(`OP_ESEC);
			addr4({16'h0000, 2'h0, a[1:0], 4'h0, 8'h07}, 2'h0);
			i_host.stop();
			`CHK(sec_area, a[1:0])
		end
	endtask
	// Wrap bits ride on clock 9 only; every other clock carries ones
	task automatic t_wrap;
		i_host.start();
		sb(`OP_WRAP);
		for (int i = 0; i < 4; i++) i_host.xfer(8'hff, 2'h2, 1'b1, r);
		i_host.xfer(8'h5f, 2'h2, 1'b1, r);
		i_host.stop();
		`CHK(wrap_setting_byte, 8'h50)
	endtask
	task automatic t_unk;
		int o;
		o = n_op;
		i_host.start();
		sb(8'hff);
		i_host.xfer(8'h00, 2'h0, 1'b0, r);
		`CHK(io_oe, 4'h0)
		i_host.stop();
		`CHK(n_op, o)
	endtask
	// Main sequence
	initial begin
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		rd_reg(`OP_RSR1, status1);
		rd_reg(`OP_RSR2, status2);
		rd_reg(`OP_RSR3, status3);
		t_ext();
		t_mode();
		t_dor();
		t_qio();
		t_did();
		t_prog();
		t_sec();
		t_wrap();
		t_unk();
		summarize();
	end
endmodule
bind sfc_core sfc_core_monitor i_mon (.clk, .rst, .cs_n, .io_oe, .pg_valid, .pg_ready, .pg_data, .op_pulse,
	.op_code, .op_data, .cmd_addr, .susp_pulse, .resume_pulse, .sec_area, .four_byte_mode,
	.upper_address_extension_byte, .wrap_setting_byte);
